// *** rtl/ppp_defs.svh ***
// Constants for the parallel programming port: commands, actions, field positions, timing.
// Assumes inclusion by the package and the design modules; definitions only.
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3

`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_PROT 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_RD_ID 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02

`define PPP_ADDR_HI_MASK 8'h03
`define PPP_FUSE_MASK 8'h1F
`define PPP_FUSE_RESET 5'h12
`define PPP_PROT_MASK 8'h06
`define PPP_BYTE_ERASED 8'hFF
`define PPP_ID_SEL_MAX 8'h02
`define PPP_PROT1_BIT 1
`define PPP_PROT2_BIT 2

`define PPP_CLK_MHZ 250
`define PPP_BUSY_MIN_NS 2500
`define PPP_OP_TIME_US 700
`define PPP_OP_CYCLES (`PPP_OP_TIME_US * `PPP_CLK_MHZ)

`endif

// *** rtl/ppp_pkg.sv ***
// Types shared by the programming port modules.
// Assumes ppp_defs.svh is on the include path.
`include "ppp_defs.svh"
package ppp_pkg;
    // Programmer control pins, grouped.
    typedef struct packed {
        logic [1:0] action;
        logic byte_select;
        logic load_pulse_pin;
        logic write_n;
        logic output_enable_n;
    } ppp_ctrl_t;

    typedef enum logic [3:0] {
        PPP_IDLE = 4'h1,
        PPP_FLASH = 4'h2,
        PPP_ERASE = 4'h4,
        PPP_DONE = 4'h8
    } ppp_state_t;
endpackage : ppp_pkg

// *** rtl/ppp_sync.sv ***
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module ppp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bundle
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    // First stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= INIT;
            q <= INIT;
        end
        else
        begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule : ppp_sync

// *** rtl/ppp_port.sv ***
// Parallel programming port: command, address and data latches, flash array,
// fuse and protection bits, timed write and erase with a ready/busy answer.
// Assumes the programmer drives the pins asynchronously; clk runs at 250 MHz.
`timescale 1ns/1ps
`include "ppp_defs.svh"

// Functional notes
// - Erase clears flash, and protection with the last word; fuses kept
// - Action 10 load pulse latches command
// - Command 80 plus write strobe erases
// - Command 10 selects flash byte programming
// - Action 00 loads address byte by select
// - Action 01 loads pending data byte
// - Write strobe programs low or high byte
// - Command and address retained across operations
// - Command 02 reads flash word bytes
// - Command 40 writes five fuse bits
// - Command 20 writes protection bits 2, 1
// - Only erase unprograms protection bits; reset here also loads them unprogrammed (2'h3)
// - Command 04 reads fuses and protection
// - Command 08 reads identification bytes
// - Identification address 00 high gives calibration
// - Busy low within 2.5 us of strobe
// - Busy lasts 0.5 to 0.9 ms
// - Ready high when idle, low when busy
// - Data bus driven only while output enable low
// - Protection bit 1 blocks programming; both block reads
// - Action 11 load pulse does nothing
module ppp_port #(
    parameter int WORDS = 1024,
    parameter int OP_CYCLES = `PPP_OP_CYCLES,
    parameter logic [7:0] ID_BYTE0 = 8'h5A, // Arbitrary value.
    parameter logic [7:0] ID_BYTE1 = 8'hA5, // Arbitrary value.
    parameter logic [7:0] ID_BYTE2 = 8'h3C, // Arbitrary value.
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Programmer control pins
    input wire ppp_pkg::ppp_ctrl_t ctrl,
    // Data bus pin
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Status pin
    output logic ready_busy_n,
    // Fuse and protection state toward the chip
    output logic internal_load_cap_fuse,
    output logic [3:0] clock_source_fuses,
    output logic protection_bit_1,
    output logic protection_bit_2
);
    localparam int AW = $clog2(WORDS);
    localparam int CW = $clog2(OP_CYCLES + 1);
    localparam ppp_pkg::ppp_ctrl_t CTRL_INIT = '{
        action: `PPP_ACT_IDLE, byte_select: 1'b0, load_pulse_pin: 1'b0,
        write_n: 1'b1, output_enable_n: 1'b1};

    ppp_pkg::ppp_ctrl_t cs;
    logic [7:0] ds;
    logic load_d_r;
    logic wr_d_r;
    logic load_ev;
    logic wr_ev;

    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] addr_hi_r, addr_hi_nxt;
    logic [7:0] addr_lo_r, addr_lo_nxt;
    logic [7:0] data_r, data_nxt;
    logic [4:0] fuse_r, fuse_nxt;
    logic [2:1] prot_r, prot_nxt;
    logic op_hi_r, op_hi_nxt;
    logic [AW-1:0] op_addr_r, op_addr_nxt;
    logic [AW-1:0] ers_addr_r, ers_addr_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    ppp_pkg::ppp_state_t st_r, st_nxt;
    logic [7:0] mem_lo [WORDS];
    logic [7:0] mem_hi [WORDS];
    logic [7:0] dout_nxt;
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;
    logic [AW-1:0] addr;

    // Control pins and data bus pass two flops before use.
    ppp_sync #(.W($bits(ppp_pkg::ppp_ctrl_t)), .INIT(CTRL_INIT)) u_sync_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .d(ctrl),
        .q(cs)
    );
    ppp_sync #(.W(8), .INIT(8'h00)) u_sync_data (
        .clk(clk),
        .rst_n(rst_n),
        .d(data_in),
        .q(ds)
    );

    // Edge detection on synchronised load pulse and write strobe.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_d_r <= 1'b0;
            wr_d_r <= 1'b1;
        end
        else
        begin
            load_d_r <= cs.load_pulse_pin;
            wr_d_r <= cs.write_n;
        end
    end

    assign load_ev = cs.load_pulse_pin && !load_d_r;
    assign wr_ev = !cs.write_n && wr_d_r && (st_r == ppp_pkg::PPP_IDLE);
    assign addr = AW'({addr_hi_r & `PPP_ADDR_HI_MASK, addr_lo_r});
    assign rd_lo = mem_lo[addr];
    assign rd_hi = mem_hi[addr];

    // Latches for command, address and data, plus the operation state machine.
    always_comb
    begin
        cmd_nxt = cmd_r;
        addr_hi_nxt = addr_hi_r;
        addr_lo_nxt = addr_lo_r;
        data_nxt = data_r;
        fuse_nxt = fuse_r;
        prot_nxt = prot_r;
        op_hi_nxt = op_hi_r;
        op_addr_nxt = op_addr_r;
        ers_addr_nxt = ers_addr_r;
        cnt_nxt = cnt_r;
        st_nxt = st_r;
        if (load_ev && st_r == ppp_pkg::PPP_IDLE)
        begin
            case (cs.action)
                `PPP_ACT_CMD: cmd_nxt = ds;
                `PPP_ACT_ADDR:
                begin
                    if (cs.byte_select)
                        addr_hi_nxt = ds & `PPP_ADDR_HI_MASK;
                    else
                        addr_lo_nxt = ds;
                end
                `PPP_ACT_DATA: data_nxt = ds;
                default: ;
            endcase
        end
        case (st_r)
            ppp_pkg::PPP_IDLE:
            begin
                if (wr_ev)
                begin
                    cnt_nxt = CW'(OP_CYCLES - 1);
                    op_hi_nxt = cs.byte_select;
                    op_addr_nxt = addr;
                    ers_addr_nxt = '0;
                    case (cmd_r)
                        `PPP_CMD_ERASE: st_nxt = ppp_pkg::PPP_ERASE;
                        `PPP_CMD_WR_FLASH: st_nxt = ppp_pkg::PPP_FLASH;
                        `PPP_CMD_WR_FUSE:
                        begin
                            if (prot_r[`PPP_PROT1_BIT])
                                fuse_nxt = data_r[4:0];
                            st_nxt = ppp_pkg::PPP_DONE;
                        end
                        `PPP_CMD_WR_PROT:
                        begin
                            // Writes can only program, never release.
                            prot_nxt = prot_r & data_r[2:1];
                            st_nxt = ppp_pkg::PPP_DONE;
                        end
                        default: st_nxt = ppp_pkg::PPP_IDLE;
                    endcase
                end
            end
            ppp_pkg::PPP_FLASH:
            begin
                cnt_nxt = cnt_r - CW'(1);
                st_nxt = ppp_pkg::PPP_DONE;
            end
            ppp_pkg::PPP_ERASE:
            begin
                // One word per cycle; protection released on the same clock edge that erases the last word.
                cnt_nxt = cnt_r - CW'(1);
                ers_addr_nxt = ers_addr_r + AW'(1);
                if (ers_addr_r == AW'(WORDS - 1))
                begin
                    prot_nxt = 2'h3;
                    st_nxt = ppp_pkg::PPP_DONE;
                end
            end
            ppp_pkg::PPP_DONE:
            begin
                cnt_nxt = cnt_r - CW'(1);
                if (cnt_r == '0)
                    st_nxt = ppp_pkg::PPP_IDLE;
            end
            default: st_nxt = ppp_pkg::PPP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_r <= 8'h00;
            addr_hi_r <= 8'h00;
            addr_lo_r <= 8'h00;
            data_r <= `PPP_BYTE_ERASED;
            fuse_r <= `PPP_FUSE_RESET;
            prot_r <= 2'h3;
            op_hi_r <= 1'b0;
            op_addr_r <= '0;
            ers_addr_r <= '0;
            cnt_r <= '0;
            st_r <= ppp_pkg::PPP_IDLE;
        end
        else
        begin
            cmd_r <= cmd_nxt;
            addr_hi_r <= addr_hi_nxt;
            addr_lo_r <= addr_lo_nxt;
            data_r <= data_nxt;
            fuse_r <= fuse_nxt;
            prot_r <= prot_nxt;
            op_hi_r <= op_hi_nxt;
            op_addr_r <= op_addr_nxt;
            ers_addr_r <= ers_addr_nxt;
            cnt_r <= cnt_nxt;
            st_r <= st_nxt;
        end
    end

    // Flash array: erase fills ones, programming only clears bits.
    always_ff @(posedge clk)
    begin
        if (st_r == ppp_pkg::PPP_ERASE)
        begin
            mem_lo[ers_addr_r] <= `PPP_BYTE_ERASED;
            mem_hi[ers_addr_r] <= `PPP_BYTE_ERASED;
        end
        else if (st_r == ppp_pkg::PPP_FLASH && prot_r[`PPP_PROT1_BIT])
        begin
            if (op_hi_r)
                mem_hi[op_addr_r] <= mem_hi[op_addr_r] & data_r;
            else
                mem_lo[op_addr_r] <= mem_lo[op_addr_r] & data_r;
        end
    end

    // Readback mux, registered onto the data bus.
    always_comb
    begin
        dout_nxt = `PPP_BYTE_ERASED;
        case (cmd_r)
            `PPP_CMD_RD_FLASH:
            begin
                if (prot_r != 2'h0)
                    dout_nxt = cs.byte_select ? rd_hi : rd_lo;
            end
            `PPP_CMD_RD_FUSE:
            begin
                if (cs.byte_select)
                    dout_nxt = ~`PPP_PROT_MASK | {5'h00, prot_r, 1'b0};
                else
                    dout_nxt = ~`PPP_FUSE_MASK | {3'h0, fuse_r};
            end
            `PPP_CMD_RD_ID:
            begin
                if (cs.byte_select)
                    dout_nxt = (addr_lo_r == 8'h00) ? CAL_BYTE : `PPP_BYTE_ERASED;
                else if (addr_lo_r == 8'h00)
                    dout_nxt = ID_BYTE0;
                else if (addr_lo_r == 8'h01)
                    dout_nxt = ID_BYTE1;
                else if (addr_lo_r == `PPP_ID_SEL_MAX)
                    dout_nxt = ID_BYTE2;
                else
                    dout_nxt = `PPP_BYTE_ERASED;
            end
            default: dout_nxt = `PPP_BYTE_ERASED;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            data_out <= 8'h00;
        else
            data_out <= dout_nxt;
    end

    // Pin answers.
    assign data_oe = !cs.output_enable_n;
    assign ready_busy_n = (st_r == ppp_pkg::PPP_IDLE);
    assign internal_load_cap_fuse = fuse_r[4];
    assign clock_source_fuses = fuse_r[3:0];
    assign protection_bit_1 = prot_r[`PPP_PROT1_BIT];
    assign protection_bit_2 = prot_r[`PPP_PROT2_BIT];
endmodule : ppp_port

// *** dv/ppp_port_assertions.sv ***
// Checker for the programming port, bound to every instance of ppp_port.
// Assumes the pins are driven asynchronously and pass a two-flop synchroniser.
`timescale 1ns/1ps
module ppp_port_chk #(
    parameter int WORDS = 1024,
    parameter int OP_CYCLES = 175000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Programmer pins
    input wire ppp_pkg::ppp_ctrl_t ctrl,
    input wire logic [7:0] data_in,
    // Answers
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic ready_busy_n,
    input wire logic internal_load_cap_fuse,
    input wire logic [3:0] clock_source_fuses,
    input wire logic protection_bit_1,
    input wire logic protection_bit_2
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    int busy_r;
    int busy_nxt;
    logic [4:0] fz;
    // Counts the cycles of the current busy period.
    always_comb busy_nxt = ready_busy_n ? 0 : busy_r + 1;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_r <= 0;
        else
            busy_r <= busy_nxt;
    end
    assign fz = {internal_load_cap_fuse, clock_source_fuses};
    sequence s_strobe;
        ready_busy_n && $fell(ctrl.write_n);
    endsequence
    sequence s_quiet;
        ctrl.write_n[*5] ##0 ready_busy_n;
    endsequence
    AST_BUSY_START: assert property (s_strobe |-> ##[1:6] !ready_busy_n)
        else $error("busy did not follow the write strobe");
    AST_BUSY_LEN: assert property ($rose(ready_busy_n) |->
        busy_r >= OP_CYCLES && busy_r <= OP_CYCLES + WORDS + 2)
        else $error("busy period length out of range");
    AST_BUSY_MAX: assert property (busy_r <= OP_CYCLES + WORDS + 2)
        else $error("busy period overran");
    AST_READY_HOLD: assert property (s_quiet |=> ready_busy_n)
        else $error("ready dropped without a strobe");
    AST_OE_ON: assert property ($fell(ctrl.output_enable_n) |-> ##[1:3] data_oe)
        else $error("data bus not driven under output enable");
    AST_OE_OFF: assert property (ctrl.output_enable_n[*3] |-> !data_oe)
        else $error("data bus driven without output enable");
    AST_PROT_RELEASE: assert property ($rose(protection_bit_1) || $rose(protection_bit_2)
        |-> busy_r >= WORDS && !ready_busy_n)
        else $error("protection released outside a finished erase");
    AST_FUSE_CHANGE: assert property ($changed(fz) |-> !$past(ready_busy_n)
        or ##[0:2] !ready_busy_n)
        else $error("fuses changed outside a write");
    AST_FUSE_LOCK: assert property (!protection_bit_1 |=> $stable(fz))
        else $error("fuses changed while protected");
endmodule : ppp_port_chk

bind ppp_port ppp_port_chk #(.WORDS(WORDS), .OP_CYCLES(OP_CYCLES)) chk (
    .clk(clk), .rst_n(rst_n), .ctrl(ctrl), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_n(ready_busy_n),
    .internal_load_cap_fuse(internal_load_cap_fuse),
    .clock_source_fuses(clock_source_fuses), .protection_bit_1(protection_bit_1),
    .protection_bit_2(protection_bit_2));

// *** dv/ppp_prog_model.sv ***
// Model of the external programmer that pulses the port's pins.
// Assumes its tasks are called from the bench; pins change at falling clock edges.
`timescale 1ns/1ps
module ppp_prog_model (
    // Clock
    input wire logic clk,
    // Pins toward the port
    output ppp_pkg::ppp_ctrl_t ctrl,
    output logic [7:0] data_in,
    // Answers from the port
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic ready_busy_n
);
    logic [7:0] drv;
    logic [7:0] rd_val;
    event got;
    // Released bus shows inverted stale data so a missing driver cannot pass.
    assign data_in = data_oe ? data_out : (ctrl.output_enable_n ? drv : ~drv);
    initial
    begin
        ctrl = '{2'h3, 1'b0, 1'b0, 1'b1, 1'b1};
        drv = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Sets action, select and byte, then a two-cycle load pulse.
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] b);
        ctrl.action = act;
        ctrl.byte_select = bs;
        drv = b;
        tick(1);
        ctrl.load_pulse_pin = 1'b1;
        tick(2);
        ctrl.load_pulse_pin = 1'b0;
        tick(3);
    endtask : load
    // Write strobe, an optional second one while busy, then wait for ready.
    task automatic strobe(input logic bs, input logic twice);
        ctrl.byte_select = bs;
        tick(1);
        ctrl.write_n = 1'b0;
        tick(2);
        ctrl.write_n = 1'b1;
        tick(10);
        if (twice)
        begin
            ctrl.write_n = 1'b0;
            tick(2);
            ctrl.write_n = 1'b1;
        end
        for (int n = 0; n < 200 && !ready_busy_n; n++) tick(1);
        tick(3);
    endtask : strobe
    // Output-enable read of one byte.
    task automatic read(input logic bs);
        ctrl.byte_select = bs;
        ctrl.output_enable_n = 1'b0;
        tick(6);
        rd_val = data_in;
        ->got;
        ctrl.output_enable_n = 1'b1;
        tick(3);
    endtask : read
endmodule : ppp_prog_model

// *** dv/tb.sv ***
// Self-checking bench for the programming port with a programmer model.
// Assumes short OP_CYCLES and WORDS so the run stays brief.
`timescale 1ns/1ps
`include "ppp_defs.svh"
module tb;
    logic clk;
    logic rst_n;
    ppp_pkg::ppp_ctrl_t ctrl;
    logic [7:0] din;
    logic [7:0] dout;
    logic oe;
    logic rdy;
    logic cap;
    logic [3:0] cks;
    logic p1;
    logic p2;
    logic [7:0] exp_q[$];
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] f;
    logic [7:0] g;
    // Default identification bytes and calibration byte of the port; arbitrary values.
    logic [7:0] ids[4] = '{8'h5A, 8'hA5, 8'h3C, 8'h80};
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    ppp_port #(.WORDS(16), .OP_CYCLES(50)) uut (.clk(clk), .rst_n(rst_n), .ctrl(ctrl),
        .data_in(din), .data_out(dout), .data_oe(oe), .ready_busy_n(rdy),
        .internal_load_cap_fuse(cap), .clock_source_fuses(cks),
        .protection_bit_1(p1), .protection_bit_2(p2));
    ppp_prog_model prog (.clk(clk), .ctrl(ctrl), .data_in(din), .data_out(dout),
        .data_oe(oe), .ready_busy_n(rdy));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic cmd(input logic [7:0] c);
        prog.load(2'h2, 1'b0, c);
    endtask : cmd
    task automatic adr(input logic [7:0] lo);
        prog.load(2'h0, 1'b1, 8'h00);
        prog.load(2'h0, 1'b0, lo);
    endtask : adr
    task automatic rd(input logic bs, input logic [7:0] e);
        exp_q.push_back(e);
        prog.read(bs);
    endtask : rd
    // Compares each read byte with the oldest expectation.
    always @(prog.got) chk("read", exp_q.pop_front(), prog.rd_val);
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(32'hE448));
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        prog.tick(3);
        chk("fuse", 8'h12, {3'h0, cap, cks});
        chk("prot", 8'h03, {6'h00, p2, p1});
        chk("ready", 8'h01, {7'h00, rdy});
        cmd(`PPP_CMD_ERASE);
        prog.strobe(1'b0, 1'b1);
        a = 8'($urandom_range(15));
        d = 8'($urandom_range(127));
        f = 8'($urandom);
        g = 8'($urandom);
        cmd(`PPP_CMD_WR_FLASH);
        adr(a);
        prog.load(2'h1, 1'b0, d);
        prog.strobe(1'b0, 1'b0);
        // An all-ones high byte is left as erased instead of being written.
        if (f != `PPP_BYTE_ERASED)
        begin
            prog.load(2'h1, 1'b1, f);
            prog.strobe(1'b1, 1'b0);
        end
        cmd(`PPP_CMD_RD_FLASH);
        prog.load(2'h3, 1'b0, ~a);
        rd(1'b0, d);
        rd(1'b1, f);
        adr(a ^ 8'h01);
        rd(1'b0, 8'hFF);
        cmd(`PPP_CMD_WR_FUSE);
        prog.load(2'h1, 1'b0, g);
        prog.strobe(1'b0, 1'b0);
        chk("fuse", {3'h0, g[4:0]}, {3'h0, cap, cks});
        cmd(`PPP_CMD_RD_FUSE);
        rd(1'b0, {3'h7, g[4:0]});
        rd(1'b1, 8'hFF);
        cmd(`PPP_CMD_RD_ID);
        for (int i = 0; i < 3; i++)
        begin
            prog.load(2'h0, 1'b0, 8'(i));
            rd(1'b0, ids[i]);
        end
        prog.load(2'h0, 1'b0, 8'h00);
        rd(1'b1, ids[3]);
        cmd(`PPP_CMD_WR_PROT);
        prog.load(2'h1, 1'b0, 8'hFD);
        prog.strobe(1'b0, 1'b0);
        chk("prot", 8'h02, {6'h00, p2, p1});
        cmd(`PPP_CMD_WR_FUSE);
        prog.load(2'h1, 1'b0, ~g);
        prog.strobe(1'b0, 1'b0);
        chk("fuse", {3'h0, g[4:0]}, {3'h0, cap, cks});
        cmd(`PPP_CMD_WR_FLASH);
        adr(a ^ 8'h01);
        prog.load(2'h1, 1'b0, 8'h00);
        prog.strobe(1'b0, 1'b0);
        cmd(`PPP_CMD_RD_FLASH);
        rd(1'b0, 8'hFF);
        adr(a);
        rd(1'b0, d);
        cmd(`PPP_CMD_WR_PROT);
        prog.load(2'h1, 1'b0, 8'hFB);
        prog.strobe(1'b0, 1'b0);
        prog.load(2'h1, 1'b0, 8'hFF);
        prog.strobe(1'b0, 1'b0);
        chk("prot", 8'h00, {6'h00, p2, p1});
        cmd(`PPP_CMD_RD_FUSE);
        rd(1'b1, 8'hF9);
        cmd(`PPP_CMD_RD_FLASH);
        rd(1'b0, 8'hFF);
        cmd(`PPP_CMD_ERASE);
        prog.strobe(1'b0, 1'b0);
        chk("prot", 8'h03, {6'h00, p2, p1});
        chk("fuse", {3'h0, g[4:0]}, {3'h0, cap, cks});
        cmd(`PPP_CMD_RD_FLASH);
        rd(1'b0, 8'hFF);
        end_of_test();
    end
endmodule : tb
